// ==== src/hph_power_core.sv ====
/*
  power handshake and power-state logic for the short-range radio core:
  wake lines to and from the host, reference clock request, rf gating,
  low-power oscillator sleep, fm on/off and per-channel link quality.
  assumes an apb master on core_clk; wake, strap and oscillator tick
  arrive as asynchronous pins; packet activity comes from core_clk logic.
*/
`timescale 1ns/1ps
module hph_power_core
  import hph_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // host handshake pins
  input  wire logic        deviceWakeRequest,
  output logic             hostWakeRequest,
  output logic             crystalPowerupOutput,
  input  wire logic        clockRequestPolarityStrap,
  // low-power oscillator tick pin
  input  wire logic        lowPowerOscillatorTick,
  // baseband core packet activity and link quality
  input  wire logic        txActive,
  input  wire logic        rxActive,
  input  wire logic        lqValid,
  input  wire logic [6:0]  lqChannel,
  input  wire logic        lqGood,
  // power controls
  output logic             txPowerDown,
  output logic             rxPowerDown,
  output logic             pllPowerDown,
  output logic             paPowerDown,
  output logic             lpoSelect,
  output logic             fmPowerOn,
  output logic             deviceAwake
);
  import hph_pkg::*;

  typedef struct packed {
    hph_state_t                       state;
    hph_ctrl_t                        ctrl;
    logic [15:0]                      sleepTime;
    logic [3:0]                       padSel;
    logic [6:0]                       lqSel;
    logic [15:0]                      lpCount;
    logic                             tickLast;
    logic [2:0]                       settle;
    logic                             strapDone;
    logic                             strap;
    logic                             pready;
    logic                             pslverr;
    logic [31:0]                      prdata;
    logic                             hostWake;
    logic                             xtal;
    logic                             txPd;
    logic                             rxPd;
    logic                             pllPd;
    logic                             paPd;
    logic                             lpoSel;
    logic                             fmOn;
    logic                             awake;
    logic [NUM_CHAN-1:0][LQ_W-1:0]    lqGoodCnt;
    logic [NUM_CHAN-1:0][LQ_W-1:0]    lqTotalCnt;
  } hph_core_t;

  hph_core_t   st;
  hph_core_t   next_st;

  hph_sync_if  wakeSync ();
  hph_sync_if  strapSync ();
  hph_sync_if  tickSync ();

  logic        hsActive;
  logic        devWakeAsserted;
  logic        sleepCrit;
  logic        tickEdge;
  logic        lpDone;
  logic        apbTake;
  logic        apbWrite;
  logic        needClk;
  logic        nextAwake;
  logic [31:0] rdData;
  logic        rdErr;

  // pin synchronisers
  assign wakeSync.raw  = deviceWakeRequest;
  assign strapSync.raw = clockRequestPolarityStrap;
  assign tickSync.raw  = lowPowerOscillatorTick;

  hph_pin_sync wakeSyncU (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (wakeSync.syncer)
  );
  hph_pin_sync strapSyncU (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (strapSync.syncer)
  );
  hph_pin_sync tickSyncU (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (tickSync.syncer)
  );

  // handshake qualification and sleep conditions
  always_comb begin
    hsActive = st.ctrl.uartMode && st.ctrl.hsEnable
               && (st.padSel == PADSEL_RST);
    devWakeAsserted = hsActive
                      && (wakeSync.clean ^ st.ctrl.devWakeLow);
    sleepCrit = st.ctrl.sleepOk && !txActive && !rxActive
                && !st.ctrl.hostReq;
    tickEdge = tickSync.clean && !st.tickLast;
    lpDone = tickEdge
             && (({1'b0, st.lpCount} + 17'h00001) >= {1'b0, st.sleepTime});
  end

  // apb decode: answer comes one cycle into the access phase
  assign apbTake  = psel && penable && !st.pready;
  assign apbWrite = psel && penable && st.pready && pwrite;

  // read mux, unmapped offsets answer with an error
  always_comb begin
    rdData = 32'h00000000;
    rdErr  = 1'b0;
    case (paddr)
      OFF_CTRL: begin
        rdData[CTRL_W-1:0] = st.ctrl;
      end
      OFF_STATUS: begin
        rdData = {8'h00, st.lpCount, 1'b0, st.state,
                  st.strap, wakeSync.clean, hsActive, st.awake};
      end
      OFF_SLEEPTIME: begin
        rdData[SLEEPTIME_W-1:0] = st.sleepTime;
      end
      OFF_LQSEL: begin
        rdData[CHAN_W-1:0] = st.lqSel;
      end
      OFF_LQDATA: begin
        rdData[2*LQ_W-1:0] = {st.lqTotalCnt[st.lqSel],
                              st.lqGoodCnt[st.lqSel]};
      end
      OFF_PADSEL: begin
        rdData[PADSEL_W-1:0] = st.padSel;
      end
      default: begin
        rdErr = 1'b1;
      end
    endcase
  end

  // next state of the whole block
  always_comb begin
    next_st = st;

    // bus answer, held until the access completes
    next_st.pready = apbTake;
    if (apbTake) begin
      next_st.prdata  = pwrite ? 32'h00000000 : rdData;
      next_st.pslverr = rdErr;
    end

    // register writes at the completing edge
    if (apbWrite) begin
      case (paddr)
        OFF_CTRL: begin
          next_st.ctrl = hph_ctrl_t'(pwdata[CTRL_W-1:0]);
        end
        OFF_SLEEPTIME: begin
          next_st.sleepTime = pwdata[SLEEPTIME_W-1:0];
        end
        OFF_LQSEL: begin
          if (pwdata[CHAN_W-1:0] <= LAST_CHAN) begin
            next_st.lqSel = pwdata[CHAN_W-1:0];
          end
          if (pwdata[LQSEL_CLR_BIT]) begin
            next_st.lqGoodCnt  = '0;
            next_st.lqTotalCnt = '0;
          end
        end
        OFF_PADSEL: begin
          next_st.padSel = pwdata[PADSEL_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // per-channel statistics, after any clear so a new sample survives
    if (lqValid && (lqChannel <= LAST_CHAN)) begin
      if (next_st.lqTotalCnt[lqChannel] != 8'hff) begin
        next_st.lqTotalCnt[lqChannel] =
          next_st.lqTotalCnt[lqChannel] + 8'h01;
      end
      if (lqGood && (next_st.lqGoodCnt[lqChannel] != 8'hff)) begin
        next_st.lqGoodCnt[lqChannel] =
          next_st.lqGoodCnt[lqChannel] + 8'h01;
      end
    end

    // strap caught once the synchroniser has settled
    next_st.tickLast = tickSync.clean;
    if (!st.strapDone) begin
      next_st.settle = st.settle + 3'h1;
      if (st.settle == STRAP_SETTLE) begin
        next_st.strap     = strapSync.clean;
        next_st.strapDone = 1'b1;
      end
    end

    // power state machine
    case (st.state)
      ST_AWAKE: begin
        if (!devWakeAsserted && sleepCrit) begin
          next_st.lpCount = 16'h0000;
          if (st.ctrl.lpMode != LP_NONE) begin
            next_st.state = ST_LPSLEEP;
          end else begin
            next_st.state = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (devWakeAsserted || !st.ctrl.sleepOk || st.ctrl.hostReq) begin
          next_st.state = ST_AWAKE;
        end
      end
      ST_LPSLEEP: begin
        if (tickEdge) begin
          next_st.lpCount = st.lpCount + 16'h0001;
        end
        if (lpDone || devWakeAsserted || !st.ctrl.sleepOk) begin
          next_st.state = ST_AWAKE;
        end
      end
      default: begin
        next_st.state = ST_AWAKE;
      end
    endcase

    // output flops follow the next state
    nextAwake = (next_st.state == ST_AWAKE);
    needClk   = nextAwake;
    next_st.awake  = nextAwake;
    next_st.lpoSel = (next_st.state == ST_LPSLEEP);
    // host wake: deasserted level unless handshake runs
    next_st.hostWake = (hsActive && st.ctrl.hostReq)
                       ^ st.ctrl.hostWakeLow;
    // clock request with strap polarity, idle low until strap is known
    next_st.xtal = st.strapDone
                   ? (needClk ^ st.strap) : 1'b0;
    // rf gated by packet activity
    next_st.txPd  = !(nextAwake && txActive);
    next_st.rxPd  = !(nextAwake && rxActive);
    next_st.pllPd = !(nextAwake && (txActive || rxActive));
    next_st.paPd  = !(nextAwake && txActive
                      && st.ctrl.paEnable);
    // fm has a single on/off control
    next_st.fmOn = st.ctrl.fmOn;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st           <= '0;
      st.state     <= ST_AWAKE;
      st.ctrl      <= hph_ctrl_t'(CTRL_RST);
      st.sleepTime <= SLEEPTIME_RST;
      st.padSel    <= PADSEL_RST;
      st.txPd      <= 1'b1;
      st.rxPd      <= 1'b1;
      st.pllPd     <= 1'b1;
      st.paPd      <= 1'b1;
      st.awake     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign prdata               = st.prdata;
  assign pready               = st.pready;
  assign pslverr              = st.pslverr;
  assign hostWakeRequest      = st.hostWake;
  assign crystalPowerupOutput = st.xtal;
  assign txPowerDown          = st.txPd;
  assign rxPowerDown          = st.rxPd;
  assign pllPowerDown         = st.pllPd;
  assign paPowerDown          = st.paPd;
  assign lpoSelect            = st.lpoSel;
  assign fmPowerOn            = st.fmOn;
  assign deviceAwake          = st.awake;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence sleepEntry;
    st.state == ST_AWAKE ##1 st.state == ST_SLEEP;
  endsequence
  sequence wakeInSleep;
    st.state == ST_SLEEP && devWakeAsserted;
  endsequence

  a_wake_exits_sleep: assert property (
    wakeInSleep |=> st.state == ST_AWAKE && deviceAwake)
    else $error("wake request did not end sleep");
  a_sleep_needs_criteria: assert property (
    sleepEntry |-> $past(sleepCrit) && !$past(devWakeAsserted))
    else $error("sleep entered without criteria");
  a_hs_gate_host: assert property (
    !hsActive ##1 !hsActive
      |-> hostWakeRequest == $past(st.ctrl.hostWakeLow))
    else $error("host wake driven while handshake off");
  a_pad_select_gate: assert property (
    st.padSel != PADSEL_RST && st.state == ST_SLEEP && st.ctrl.sleepOk
      && !st.ctrl.hostReq |=> !deviceAwake)
    else $error("wake honoured with nonzero pad select");
  a_clock_req_pol: assert property (
    st.strapDone && $stable(st.strap) ##1 st.strapDone
      |-> crystalPowerupOutput == (deviceAwake ^ st.strap))
    else $error("clock request level wrong for strap");
  a_rf_off_asleep: assert property (
    st.state != ST_AWAKE |-> txPowerDown && rxPowerDown
                             && pllPowerDown && paPowerDown)
    else $error("rf powered while asleep");
  a_lp_timed_wake: assert property (
    st.state == ST_LPSLEEP && lpDone |=> st.state == ST_AWAKE && !lpoSelect)
    else $error("low-power sleep overran its interval");
  a_fm_follows: assert property (
    fmPowerOn == $past(st.ctrl.fmOn))
    else $error("fm power not following control");
  a_lq_counts: assert property (
    lqValid && lqChannel <= LAST_CHAN && !apbWrite
      && st.lqTotalCnt[lqChannel] != 8'hff
      |=> st.lqTotalCnt[$past(lqChannel)]
          == $past(st.lqTotalCnt[lqChannel]) + 8'h01)
    else $error("channel sample not counted");
  a_apb_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

endmodule

// ==== src/hph_pkg.sv ====
/*
  shared constants and types for the host power handshake block:
  register offsets, reset values, control layout and state codes.
  assumes a 32-bit apb slave with byte addresses on an 8-bit paddr.
*/
package hph_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_SLEEPTIME = 8'h08;
  localparam logic [7:0] OFF_LQSEL     = 8'h0c;
  localparam logic [7:0] OFF_LQDATA    = 8'h10;
  localparam logic [7:0] OFF_PADSEL    = 8'h14;

  // field positions and widths inside written words
  localparam int unsigned LQSEL_CLR_BIT = 8;
  localparam int unsigned SLEEPTIME_W   = 16;
  localparam int unsigned PADSEL_W      = 4;

  // link-quality table shape
  localparam int unsigned NUM_CHAN  = 79;
  localparam int unsigned CHAN_W    = 7;
  localparam int unsigned LQ_W      = 8;
  localparam logic [6:0]  LAST_CHAN = 7'(NUM_CHAN - 1);

  // values after reset, and the strap settle count
  localparam logic [15:0] SLEEPTIME_RST = 16'h0020;
  localparam logic [3:0]  PADSEL_RST    = 4'h0;
  localparam logic [2:0]  STRAP_SETTLE  = 3'h4;

  // low-power connection modes
  typedef enum logic [1:0] {
    LP_NONE  = 2'h0,
    LP_SNIFF = 2'h1,
    LP_HOLD  = 2'h2,
    LP_PARK  = 2'h3
  } hph_lpmode_t;

  // control register, bit 0 upward is uartMode
  typedef struct packed {
    hph_lpmode_t lpMode;
    logic        paEnable;
    logic        fmOn;
    logic        hostReq;
    logic        sleepOk;
    logic        hostWakeLow;
    logic        devWakeLow;
    logic        hsEnable;
    logic        uartMode;
  } hph_ctrl_t;

  localparam int unsigned CTRL_W   = 10;
  localparam logic [9:0]  CTRL_RST = 10'h000;

  // power states, one-hot
  typedef enum logic [2:0] {
    ST_AWAKE   = 3'h1,
    ST_SLEEP   = 3'h2,
    ST_LPSLEEP = 3'h4
  } hph_state_t;

endpackage

// ==== src/hph_sync_if.sv ====
/*
  carrier between the core and a pin synchroniser: raw pin level in,
  agreed clean level out. assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
interface hph_sync_if;
  logic raw;
  logic clean;
  modport syncer (input raw, output clean);
  modport user   (output raw, input clean);
endinterface

// ==== src/hph_pin_sync.sv ====
/*
  three-stage pin synchroniser; the clean level follows only once the
  second and third stages agree. assumes raw is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module hph_pin_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // pin carrier
  hph_sync_if.syncer pin
);
  import hph_pkg::*;

  typedef struct packed {
    logic [2:0] stage;
    logic       clean;
  } hph_sync_st_t;

  hph_sync_st_t st;
  hph_sync_st_t next_st;

  // shift chain; stage 0 feeds only stage 1
  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[1:0], pin.raw};
    if (st.stage[1] == st.stage[2]) begin
      next_st.clean = st.stage[2];
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin.clean = st.clean;

endmodule

// ==== test/hph_host_model.sv ====
/*
  host side of the wake handshake: drives the device wake pin at the
  chosen polarity and follows the host wake line.
  assumes core_clk timing and polarities set by the bench.
*/
`timescale 1ns/1ps
module hph_host_model (
  // clock
  input  wire logic core_clk,
  // bench controls
  input  wire logic wantDevice,
  input  wire logic devWakeLow,
  input  wire logic hostWakeLow,
  // handshake pins
  output logic      deviceWakeRequest,
  input  wire logic hostWakeRequest,
  output logic      hostAwake
);
  // request the device, obey the host wake line
  always @(posedge core_clk) begin
    deviceWakeRequest <= wantDevice ^ devWakeLow;
    hostAwake <= hostWakeRequest ^ hostWakeLow;
  end
endmodule

// ==== test/tb_host_power_handshake.sv ====
/*
  self-checking bench for the power core: registers, wake and sleep,
  clock request, low-power sleep, rf gating, fm and link quality.
  assumes the host model on the wake pins and apb on core_clk.
*/
`timescale 1ns/1ps
module tb_host_power_handshake;
  import hph_pkg::*;
  logic        core_clk, reset_n, psel, penable, pwrite, pready, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pslverr, devWake, hostWake, xtal, strap, tick;
  logic        txActive, rxActive, lqValid, lqGood;
  logic [6:0]  lqChannel;
  logic        txPd, rxPd, pllPd, paPd, lpoSel, fmOn, awake;
  logic        want, dLow, hLow, hostAwake;
  int          errTotal, checked, awakeCnt = 0;

  hph_power_core u_hph_power_core (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .deviceWakeRequest(devWake),
    .hostWakeRequest(hostWake), .crystalPowerupOutput(xtal),
    .clockRequestPolarityStrap(strap), .lowPowerOscillatorTick(tick),
    .txActive(txActive), .rxActive(rxActive), .lqValid(lqValid),
    .lqChannel(lqChannel), .lqGood(lqGood), .txPowerDown(txPd),
    .rxPowerDown(rxPd), .pllPowerDown(pllPd), .paPowerDown(paPd),
    .lpoSelect(lpoSel), .fmPowerOn(fmOn), .deviceAwake(awake)
  );
  hph_host_model u_hph_host_model (
    .core_clk(core_clk), .wantDevice(want), .devWakeLow(dLow),
    .hostWakeLow(hLow), .deviceWakeRequest(devWake),
    .hostWakeRequest(hostWake), .hostAwake(hostAwake)
  );

  // 100 mhz clock
  always #5 core_clk = ~core_clk;
  // counts awake cycles
  always @(posedge core_clk) if (awake === 1'b1) awakeCnt++;

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for the awake level
  task automatic waitAwake(input logic v);
    repeat (30) if (awake !== v) @(posedge core_clk);
    chk("awake", v, awake);
  endtask
  task automatic rst(input logic s);
    reset_n <= 1'b0;
    strap   <= s;
    want    <= 1'b0;
    cyc(10);
    chk("reset pd", 32'hf, {txPd, rxPd, pllPd, paPd});
    chk("reset out", 32'h1, {xtal, hostWake, lpoSel, fmOn, awake});
    reset_n <= 1'b1;
  endtask
  function automatic logic [31:0] lqWord(input int g, input int t);
    return {16'h0, 8'(t), 8'(g)};
  endfunction
  task automatic end_of_test();
    if (errTotal == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge core_clk);
    errTotal++;
    end_of_test();
  end

  // main sequence, once per strap level
  initial begin
    int k, a0, q, g;
    int ch[3], gd[3], tt[3];
    core_clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, tick, txActive, rxActive} = '0;
    {lqValid, lqGood, strap, want, dLow, hLow} = '0;
    paddr = '0;
    pwdata = '0;
    lqChannel = '0;
    errTotal = 0;
    checked = 0;
    void'($urandom(32'ha2c3));
    for (int s = 0; s < 2; s++) begin
      rst(s[0]);
      apb(1'b0, OFF_CTRL, '0);
      chk("ctrl", {22'h0, CTRL_RST}, rd);
      apb(1'b0, OFF_SLEEPTIME, '0);
      chk("sleeptime", {16'h0, SLEEPTIME_RST}, rd);
      apb(1'b0, OFF_PADSEL, '0);
      chk("padsel", {28'h0, PADSEL_RST}, rd);
      apb(1'b0, 8'h18, '0);
      chk("unmapped", 32'h1, {rd[30:0], er});
      cyc(8);
      chk("clkreq on", {31'h0, ~s[0]}, xtal);
      apb(1'b0, OFF_STATUS, '0);
      chk("status", 32'h11 | (s << 3), rd);
      for (int p = 0; p < 4; p++) begin
        dLow <= p[0];
        hLow <= p[1];
        apb(1'b1, OFF_CTRL, 32'h13 | (p << 2));
        // let the new pin level pass the synchroniser first
        cyc(6);
        waitAwake(1'b0);
        chk("clkreq off", {31'h0, s[0]}, xtal);
        want <= 1'b1;
        waitAwake(1'b1);
        want <= 1'b0;
        waitAwake(1'b0);
        apb(1'b1, OFF_CTRL, 32'h33 | (p << 2));
        cyc(3);
        chk("host wake", {31'h0, ~p[1]}, hostWake);
        chk("host awake", 32'h1, hostAwake);
        apb(1'b1, OFF_CTRL, 32'h13 | (p << 2));
        cyc(3);
        chk("host idle", {31'h0, p[1]}, hostWake);
      end
      // wake refused by pad select, then by uart mode off
      dLow <= 1'b0;
      apb(1'b1, OFF_PADSEL, 32'h1);
      apb(1'b1, OFF_CTRL, 32'h13);
      waitAwake(1'b0);
      want <= 1'b1;
      cyc(20);
      chk("pad wake", 32'h0, awake);
      apb(1'b1, OFF_PADSEL, 32'h0);
      waitAwake(1'b1);
      want <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h12);
      waitAwake(1'b0);
      want <= 1'b1;
      cyc(20);
      chk("uart wake", 32'h0, awake);
      want <= 1'b0;
      // sniff, hold, park wake after the programmed tick count
      for (int m = 1; m < 4; m++) begin
        k = $urandom_range(2, 5);
        apb(1'b1, OFF_CTRL, 32'h3);
        waitAwake(1'b1);
        apb(1'b1, OFF_SLEEPTIME, 32'(k));
        apb(1'b1, OFF_CTRL, 32'h13 | (m << 8));
        waitAwake(1'b0);
        cyc(2);
        chk("lpo", 32'h1, lpoSel);
        for (int i = 1; i <= k; i++) begin
          a0 = awakeCnt;
          tick <= 1'b1;
          cyc(5);
          tick <= 1'b0;
          cyc(12);
          chk("lp wake", i == k, awakeCnt != a0);
        end
      end
      // rf gating follows packet activity
      apb(1'b1, OFF_CTRL, 32'h83);
      waitAwake(1'b1);
      for (int j = 1; j < 3; j++) begin
        {txActive, rxActive} <= 2'(j);
        cyc(3);
        chk("tx pd", {31'h0, ~j[1]}, txPd);
        chk("rx pd", {31'h0, ~j[0]}, rxPd);
        chk("pa pd", {31'h0, ~j[1]}, paPd);
        chk("pll pd", 32'h0, pllPd);
      end
      {txActive, rxActive} <= 2'h0;
      for (int f = 1; f >= 0; f--) begin
        apb(1'b1, OFF_CTRL, 32'h3 | (f << 6));
        cyc(2);
        chk("fm", f, fmOn);
      end
      // link quality per channel, with an out-of-range select
      apb(1'b1, OFF_LQSEL, 32'h100);
      ch = '{0, int'(LAST_CHAN), $urandom_range(1, 77)};
      gd = '{0, 0, 0};
      tt = '{0, 0, 0};
      repeat (30) begin
        q = $urandom_range(0, 2);
        g = $urandom_range(0, 1);
        @(posedge core_clk);
        lqValid   <= 1'b1;
        lqChannel <= 7'(ch[q]);
        lqGood    <= g[0];
        tt[q]++;
        gd[q] += g;
      end
      @(posedge core_clk);
      lqValid <= 1'b0;
      for (int c = 0; c < 3; c++) begin
        apb(1'b1, OFF_LQSEL, 32'(ch[c]));
        apb(1'b0, OFF_LQDATA, '0);
        chk("lq", lqWord(gd[c], tt[c]), rd);
      end
      apb(1'b1, OFF_LQSEL, 32'h7f);
      apb(1'b0, OFF_LQDATA, '0);
      chk("lq keep", lqWord(gd[2], tt[2]), rd);
    end
    end_of_test();
  end
endmodule
